// [rtl/dbar_ctl.sv]
`timescale 1ns/1ps
module dbar_ctl
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  dbar_if.ctl                               lnk,
  input  wire logic                         req_valid,
  input  wire logic [dbar_pkg::BANK_W-1:0]  req_bank,
  input  wire logic [dbar_pkg::ROW_W-1:0]   req_row,
  input  wire logic [dbar_pkg::COL_W-1:0]   req_col,
  input  wire logic                         req_ap,
  output logic                              req_ready,
  output logic [dbar_pkg::DQ_W-1:0]         data,
  output logic                              data_valid
);
  typedef enum logic [1:0] {
    DBAR_ST_IDLE = 2'h0,
    DBAR_ST_ACT  = 2'h1,
    DBAR_ST_RD   = 2'h2,
    DBAR_ST_PRE  = 2'h3
  } dbar_st_t;
  typedef struct packed {
    dbar_st_t                               st;
    logic [2:0]                             div;
    logic                                   ck;
    logic [dbar_pkg::NUM_BANKS-1:0]          open;
    logic [dbar_pkg::NUM_BANKS-1:0][dbar_pkg::ROW_W-1:0] row;
    logic [dbar_pkg::NUM_BANKS-1:0][3:0]     rc_cnt;
    logic [dbar_pkg::NUM_BANKS-1:0][3:0]     rcd_cnt;
    logic [3:0]                             rrd_cnt;
    logic [3:0]                             wait_cnt;
    dbar_pkg::dbar_cmd_t                    cmd;
    logic [dbar_pkg::BANK_W-1:0]            bank;
    logic [dbar_pkg::ROW_W-1:0]             addr;
    logic [1:0]                             stb_sync;
    logic                                   stb_prev;
    logic [1:0][dbar_pkg::DQ_W-1:0]         dq_sync;
    logic [dbar_pkg::DQ_W-1:0]              data;
    logic                                   data_valid;
    logic                                   req_ready;
  } dbar_ctl_t;
  dbar_ctl_t s;
  dbar_ctl_t next_s;
  logic rise;
  logic [1:0] b;
  assign b    = req_bank;
  assign rise = (s.div == dbar_pkg::DIV_HALF - 3'h1) && !s.ck;
  always_comb
  begin
    next_s            = s;
    next_s.data_valid = 1'b0;
    next_s.req_ready  = 1'b0;
    next_s.div        = (s.div == dbar_pkg::DIV_HALF - 3'h1) ? 3'h0 : s.div + 3'h1;
    if (s.div == dbar_pkg::DIV_HALF - 3'h1)
      next_s.ck = ~s.ck;
    next_s.stb_sync = {s.stb_sync[0], lnk.read_strobe[0] & lnk.strobe_oe};
    next_s.stb_prev = s.stb_sync[1];
    next_s.dq_sync  = {s.dq_sync[0], lnk.dq_out};
    if ((s.stb_sync[1] != s.stb_prev) && lnk.dq_oe)
    begin
      next_s.data       = s.dq_sync[1];
      next_s.data_valid = 1'b1;
    end
    if (rise)
    begin
      next_s.cmd = dbar_pkg::DBAR_CMD_NOP;
      for (int i = 0; i < dbar_pkg::NUM_BANKS; i++)
      begin
        if (s.rc_cnt[i] != 4'h0)
          next_s.rc_cnt[i] = s.rc_cnt[i] - 4'h1;
        if (s.rcd_cnt[i] != 4'h0)
          next_s.rcd_cnt[i] = s.rcd_cnt[i] - 4'h1;
      end
      if (s.rrd_cnt != 4'h0)
        next_s.rrd_cnt = s.rrd_cnt - 4'h1;
      if (s.wait_cnt != 4'h0)
        next_s.wait_cnt = s.wait_cnt - 4'h1;
      case (s.st)
        DBAR_ST_IDLE:
        begin
          if (req_valid && s.wait_cnt == 4'h0)
          begin
            if (s.open[b] && s.row[b] == req_row)
              next_s.st = DBAR_ST_RD;
            else if (s.open[b])
              next_s.st = DBAR_ST_PRE;
            else
              next_s.st = DBAR_ST_ACT;
          end
        end
        DBAR_ST_PRE:
        begin
          next_s.cmd     = dbar_pkg::DBAR_CMD_PRE;
          next_s.bank    = b;
          next_s.addr    = '0;
          next_s.open[b] = 1'b0;
          next_s.wait_cnt = dbar_pkg::RP_CNT;
          next_s.st      = DBAR_ST_IDLE;
        end
        DBAR_ST_ACT:
        begin
          if (s.rc_cnt[b] == 4'h0 && s.rrd_cnt == 4'h0)
          begin
            next_s.cmd        = dbar_pkg::DBAR_CMD_ACT;
            next_s.bank       = b;
            next_s.addr       = req_row;
            next_s.open[b]    = 1'b1;
            next_s.row[b]     = req_row;
            next_s.rc_cnt[b]  = dbar_pkg::RC_CNT;
            next_s.rcd_cnt[b] = dbar_pkg::RCD_CNT;
            next_s.rrd_cnt    = dbar_pkg::RRD_CNT;
            next_s.st         = DBAR_ST_RD;
          end
        end
        DBAR_ST_RD:
        begin
          if (s.rcd_cnt[b] == 4'h0)
          begin
            next_s.cmd  = dbar_pkg::DBAR_CMD_READ;
            next_s.bank = b;
            next_s.addr = '0;
            next_s.addr[dbar_pkg::COL_W-1:0] = req_col;
            next_s.addr[dbar_pkg::AP_BIT]    = req_ap;
            if (req_ap)
              next_s.open[b] = 1'b0;
            // auto precharge: hold off until burst done and bank precharged
            if (req_ap)
              next_s.wait_cnt = 4'(dbar_pkg::CAS_LATENCY + dbar_pkg::BURST_LEN / 2 + 1)
                                + dbar_pkg::RP_CNT;
            else
              next_s.wait_cnt = 4'(dbar_pkg::NIBBLES - 1);
            next_s.req_ready = 1'b1;
            next_s.st        = DBAR_ST_IDLE;
          end
        end
        default:
          next_s.st = DBAR_ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s    <= '0;
      s.st <= DBAR_ST_IDLE;
    end
    else
      s <= next_s;
  end
  assign lnk.link_ck = s.ck;
  assign lnk.cmd     = s.cmd;
  assign lnk.bank    = s.bank;
  assign lnk.addr    = s.addr;
  assign req_ready   = s.req_ready;
  assign data        = s.data;
  assign data_valid  = s.data_valid;
endmodule

// [rtl/dbar_if.sv]
`timescale 1ns/1ps
interface dbar_if;
  logic                       link_ck;
  dbar_pkg::dbar_cmd_t        cmd;
  logic [dbar_pkg::BANK_W-1:0] bank;
  logic [dbar_pkg::ROW_W-1:0]  addr;
  logic [dbar_pkg::DQ_W-1:0]   dq_out;
  logic                       dq_oe;
  logic [dbar_pkg::LANES-1:0]  read_strobe;
  logic                       strobe_oe;
  logic                       term_on;
  modport mem
  (
    input  link_ck, cmd, bank, addr,
    output dq_out, dq_oe, read_strobe, strobe_oe, term_on
  );
  modport ctl
  (
    output link_ck, cmd, bank, addr,
    input  dq_out, dq_oe, read_strobe, strobe_oe, term_on
  );
endinterface

// [rtl/dbar_mem.sv]
`timescale 1ns/1ps
module dbar_mem
(
  input  wire logic clk,
  input  wire logic nrst,
  dbar_if.mem       lnk,
  input  wire logic [dbar_pkg::DQ_W-1:0] rd_word,
  input  wire logic                     rd_word_valid,
  output logic                          rd_word_ready,
  output logic                          rd_req,
  output logic [dbar_pkg::BANK_W-1:0]   rd_bank,
  output logic [dbar_pkg::ROW_W-1:0]    rd_row,
  output logic [dbar_pkg::COL_W-1:0]    rd_col,
  output logic                          bad_cmd
);
  localparam int QD = 16;
  typedef struct packed {
    logic [1:0]                                       ck_sync;
    logic                                             ck_prev;
    logic [dbar_pkg::NUM_BANKS-1:0]                   open;
    logic [dbar_pkg::NUM_BANKS-1:0][dbar_pkg::ROW_W-1:0] row;
    logic [dbar_pkg::NUM_BANKS-1:0][3:0]              ras_cnt;
    logic [dbar_pkg::NUM_BANKS-1:0]                   ap_pend;
    logic [QD-1:0]                                    rd_pipe;
    logic [1:0][dbar_pkg::DQ_W-1:0]                   buf_data;
    logic [1:0]                                       buf_full;
    logic                                             word_rdy;
    logic [2:0]                                       elem_left;
    logic [dbar_pkg::DQ_W-1:0]                        dq_out;
    logic                                             dq_oe;
    logic [dbar_pkg::LANES-1:0]                       strobe;
    logic                                             strobe_oe;
    logic                                             term_on;
    logic                                             rd_req;
    logic [dbar_pkg::BANK_W-1:0]                      rd_bank;
    logic [dbar_pkg::ROW_W-1:0]                       rd_row;
    logic [dbar_pkg::COL_W-1:0]                       rd_col;
    logic                                             bad_cmd;
  } dbar_mem_t;
  dbar_mem_t s;
  dbar_mem_t next_s;
  logic ck_rise;
  logic ck_fall;
  logic [1:0] cmd_bank;
  logic pipe_busy;
  assign pipe_busy = |s.rd_pipe[dbar_pkg::CAS_LATENCY-1:0];
  assign ck_rise  = s.ck_sync[1] & ~s.ck_prev;
  assign ck_fall  = ~s.ck_sync[1] & s.ck_prev;
  assign cmd_bank = lnk.bank;
  always_comb
  begin
    next_s            = s;
    next_s.ck_sync    = {s.ck_sync[0], lnk.link_ck};
    next_s.ck_prev    = s.ck_sync[1];
    next_s.rd_req     = 1'b0;
    next_s.bad_cmd    = 1'b0;
    if (ck_rise)
    begin
      next_s.rd_pipe = {s.rd_pipe[QD-2:0], 1'b0};
      for (int b = 0; b < dbar_pkg::NUM_BANKS; b++)
      begin
        if (s.ras_cnt[b] != 4'h0)
          next_s.ras_cnt[b] = s.ras_cnt[b] - 4'h1;
        if (s.ap_pend[b] && s.ras_cnt[b] <= 4'h1 && s.elem_left == 3'h0
            && !pipe_busy)
        begin
          next_s.ap_pend[b] = 1'b0;
          next_s.open[b]    = 1'b0;
        end
      end
      case (lnk.cmd)
        dbar_pkg::DBAR_CMD_ACT:
        begin
          next_s.open[cmd_bank]    = 1'b1;
          next_s.row[cmd_bank]     = lnk.addr;
          next_s.ras_cnt[cmd_bank] = dbar_pkg::RAS_CNT;
        end
        dbar_pkg::DBAR_CMD_READ:
        begin
          if (s.open[cmd_bank])
          begin
            next_s.rd_req     = 1'b1;
            next_s.rd_bank    = cmd_bank;
            next_s.rd_row     = s.row[cmd_bank];
            next_s.rd_col     = lnk.addr[dbar_pkg::COL_W-1:0];
            next_s.ap_pend[cmd_bank] = lnk.addr[dbar_pkg::AP_BIT];
            next_s.rd_pipe[0] = 1'b1;
          end
          else
            next_s.bad_cmd = 1'b1;
        end
        dbar_pkg::DBAR_CMD_PRE:
        begin
          if (lnk.addr[dbar_pkg::AP_BIT])
            next_s.open = '0;
          else
            next_s.open[cmd_bank] = 1'b0;
        end
        default:
        begin
        end
      endcase
      // burst start after cas latency, queued after running burst
      if (s.rd_pipe[dbar_pkg::CAS_LATENCY-1])
        next_s.elem_left = s.elem_left + 3'(dbar_pkg::BURST_LEN);
    end
    // preamble one half clock early
    if (ck_fall && s.rd_pipe[dbar_pkg::CAS_LATENCY-1] && s.elem_left == 3'h0)
    begin
      next_s.strobe_oe = 1'b1;
      next_s.strobe    = '1;
    end
    if ((ck_rise || ck_fall) && next_s.elem_left != 3'h0 && s.buf_full[0])
    begin
      next_s.dq_out    = s.buf_data[0];
      next_s.dq_oe     = 1'b1;
      next_s.strobe_oe = 1'b1;
      next_s.strobe    = {dbar_pkg::LANES{ck_fall}};
      next_s.elem_left = next_s.elem_left - 3'h1;
      next_s.buf_data[0] = s.buf_data[1];
      next_s.buf_full    = {1'b0, s.buf_full[1]};
    end
    else if ((ck_rise || ck_fall) && s.dq_oe && s.elem_left == 3'h0)
    begin
      next_s.dq_oe     = 1'b0;
      next_s.strobe_oe = 1'b0;
      next_s.strobe    = '0;
    end
    // two-entry buffer takes a word after any pop, so none is lost
    if (rd_word_valid && s.word_rdy)
    begin
      if (!next_s.buf_full[0])
      begin
        next_s.buf_data[0] = rd_word;
        next_s.buf_full[0] = 1'b1;
      end
      else
      begin
        next_s.buf_data[1] = rd_word;
        next_s.buf_full[1] = 1'b1;
      end
    end
    next_s.word_rdy = ~next_s.buf_full[1];
    next_s.term_on = ~(pipe_busy || next_s.elem_left != 3'h0 || next_s.dq_oe);
  end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s         <= '0;
      s.term_on <= 1'b1;
    end
    else
      s <= next_s;
  end
  assign lnk.dq_out      = s.dq_out;
  assign lnk.dq_oe       = s.dq_oe;
  assign lnk.read_strobe = s.strobe;
  assign lnk.strobe_oe   = s.strobe_oe;
  assign lnk.term_on     = s.term_on;
  assign rd_req          = s.rd_req;
  assign rd_word_ready   = s.word_rdy;
  assign rd_bank         = s.rd_bank;
  assign rd_row          = s.rd_row;
  assign rd_col          = s.rd_col;
  assign bad_cmd         = s.bad_cmd;
endmodule

// [rtl/dbar_pkg.sv]
package dbar_pkg;
  localparam int NUM_BANKS        = 4;
  localparam int BANK_W           = 2;
  localparam int ROW_W            = 12;
  localparam int COL_W            = 8;
  localparam int DQ_W             = 32;
  localparam int LANES            = 4;
  localparam int LANE_W           = 8;
  localparam int BURST_LEN        = 4;
  localparam int NIBBLES          = BURST_LEN / 4;
  localparam int AP_BIT           = 8;
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int LINK_DIV         = 6;
  localparam int CAS_LATENCY      = 7;
  localparam int T_RCD_PS         = 16000;
  localparam int T_RC_PS          = 48000;
  localparam int T_RRD_PS         = 8000;
  localparam int T_RAS_PS         = 32000;
  localparam int T_RP_PS          = 16000;
  localparam int LINK_PERIOD_PS   = CLK_PERIOD_PS * LINK_DIV;
  localparam int RCD_CK   = (T_RCD_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RC_CK    = (T_RC_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RRD_CK   = (T_RRD_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RAS_CK   = (T_RAS_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RP_CK    = (T_RP_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam logic [3:0] RCD_CNT = 4'(RCD_CK);
  localparam logic [3:0] RC_CNT  = 4'(RC_CK);
  localparam logic [3:0] RRD_CNT = 4'(RRD_CK);
  localparam logic [3:0] RAS_CNT = 4'(RAS_CK);
  localparam logic [3:0] RP_CNT  = 4'(RP_CK);
  localparam logic [3:0] CL_CNT  = 4'(CAS_LATENCY);
  localparam logic [2:0] DIV_HALF = 3'(LINK_DIV / 2);
  localparam logic [1:0] ADDR_DATA = 2'h0;
  typedef enum logic [2:0] {
    DBAR_CMD_NOP  = 3'h0,
    DBAR_CMD_ACT  = 3'h1,
    DBAR_CMD_READ = 3'h2,
    DBAR_CMD_PRE  = 3'h3
  } dbar_cmd_t;
endpackage

// [sim/dbar_bank_activate_read_path_tb_top.sv]
`timescale 1ns/1ps
module dbar_bank_activate_read_path_tb_top;
  logic        clk;
  logic        nrst;
  logic        req_valid;
  logic [1:0]  req_bank;
  logic [11:0] req_row;
  logic [7:0]  req_col;
  logic        req_ap;
  logic        req_ready;
  logic [31:0] data;
  logic        data_valid;
  logic [31:0] rd_word;
  logic        rd_word_valid;
  logic        rd_word_ready;
  logic [31:0] arr_q[$];
  logic        rd_req;
  logic [1:0]  rd_bank;
  logic [11:0] rd_row;
  logic [7:0]  rd_col;
  logic        bad_cmd;
  logic        bad_cmd2;
  logic        bad_seen = 1'b0;
  logic [31:0] got[$];
  int          failures;
  int          num_checks;
  dbar_if lnk ();
  dbar_if lnk2 ();
  dbar_ctl dbar_ctl_inst (.clk(clk), .nrst(nrst), .lnk(lnk), .req_valid(req_valid),
    .req_bank(req_bank), .req_row(req_row), .req_col(req_col), .req_ap(req_ap),
    .req_ready(req_ready), .data(data), .data_valid(data_valid));
  dbar_mem dbar_mem_inst (.clk(clk), .nrst(nrst), .lnk(lnk), .rd_word(rd_word),
    .rd_word_valid(rd_word_valid), .rd_word_ready(rd_word_ready),
    .rd_req(rd_req), .rd_bank(rd_bank), .rd_row(rd_row),
    .rd_col(rd_col), .bad_cmd(bad_cmd));
  dbar_mem dbar_mem_inst2 (.clk(clk), .nrst(nrst), .lnk(lnk2), .rd_word(32'h00000000),
    .rd_word_valid(1'b0), .rd_word_ready(), .rd_req(), .rd_bank(), .rd_row(), .rd_col(),
    .bad_cmd(bad_cmd2));
  dbar_sva dbar_sva_inst (.clk(clk), .nrst(nrst), .link_ck(lnk.link_ck), .cmd(lnk.cmd),
    .bank(lnk.bank), .addr(lnk.addr), .dq_out(lnk.dq_out), .dq_oe(lnk.dq_oe),
    .read_strobe(lnk.read_strobe), .strobe_oe(lnk.strobe_oe), .term_on(lnk.term_on));
  always #2 clk = ~clk;
  function automatic logic [31:0] word_of(logic [1:0] b, logic [11:0] r, logic [7:0] c);
    return {4'hA, 2'h0, b, r, c, 4'h5};
  endfunction
  // array model queues four words per request, held until taken; monitor collects words
  always @(posedge clk)
  begin
    if (rd_word_valid === 1'b1 && rd_word_ready === 1'b1)
      arr_q.delete(0);
    if (rd_req === 1'b1)
      for (int i = 0; i < 4; i++)
        arr_q.push_back(word_of(rd_bank, rd_row, rd_col + 8'(i)));
    rd_word_valid <= (arr_q.size() > 0);
    rd_word <= (arr_q.size() > 0) ? arr_q[0] : 32'h00000000;
    if (bad_cmd === 1'b1)
      bad_seen <= 1'b1;
    if (data_valid === 1'b1)
      got.push_back(data);
  end
  task automatic print_verdict();
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic req(logic [1:0] b, logic [11:0] r, logic [7:0] c, logic ap);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_bank <= b;
    req_row <= r;
    req_col <= c;
    req_ap <= ap;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 3000);
    @(posedge clk);
    req_valid <= 1'b0;
    check("req_ready", 32'(n < 3000), 32'h1);
  endtask
  task automatic burst(logic [1:0] b, logic [11:0] r, logic [7:0] c);
    int n;
    n = 0;
    while (got.size() < 4 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    for (int i = 0; i < 4; i++)
      check("data", (got.size() > 0) ? got.pop_front() : 32'hFFFFFFFF, word_of(b, r, c + 8'(i)));
  endtask
  task automatic t_single();
    req(2'h0, 12'h123, 8'h10, 1'b0);
    burst(2'h0, 12'h123, 8'h10);
  endtask
  task automatic t_banks();
    req(2'h1, 12'h111, 8'h20, 1'b0);
    req(2'h2, 12'h222, 8'h30, 1'b0);
    req(2'h3, 12'h333, 8'h40, 1'b0);
    req(2'h0, 12'h123, 8'h50, 1'b0);
    burst(2'h1, 12'h111, 8'h20);
    burst(2'h2, 12'h222, 8'h30);
    burst(2'h3, 12'h333, 8'h40);
    burst(2'h0, 12'h123, 8'h50);
  endtask
  task automatic t_gapless();
    req(2'h1, 12'h111, 8'h60, 1'b0);
    req(2'h1, 12'h111, 8'h64, 1'b0);
    burst(2'h1, 12'h111, 8'h60);
    burst(2'h1, 12'h111, 8'h64);
  endtask
  task automatic t_autopre();
    req(2'h2, 12'h0AA, 8'h00, 1'b1);
    req(2'h2, 12'h0BB, 8'h08, 1'b0);
    burst(2'h2, 12'h0AA, 8'h00);
    burst(2'h2, 12'h0BB, 8'h08);
    check("bad_cmd", 32'(bad_seen), 32'h0);
  endtask
  // read to a bank never activated: refused, no drive, termination kept
  task automatic t_idle_read();
    logic seen;
    logic oe;
    seen = 1'b0;
    oe = 1'b0;
    for (int k = 0; k < 60; k++)
    begin
      @(posedge clk);
      if (k % 6 == 0)
        lnk2.link_ck <= ~lnk2.link_ck;
      if (k == 0)
        lnk2.cmd <= dbar_pkg::DBAR_CMD_READ;
      if (k == 12)
        lnk2.cmd <= dbar_pkg::DBAR_CMD_NOP;
      seen = seen | (bad_cmd2 === 1'b1);
      oe = oe | (lnk2.dq_oe !== 1'b0) | (lnk2.term_on !== 1'b1);
    end
    check("bad_cmd2", 32'(seen), 32'h1);
    check("idle_drive", 32'(oe), 32'h0);
  endtask
  initial
  begin
    #100000;
    failures++;
    print_verdict();
  end
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    req_valid = 1'b0;
    req_bank = 2'h0;
    req_row = 12'h000;
    req_col = 8'h00;
    req_ap = 1'b0;
    rd_word = 32'h00000000;
    rd_word_valid = 1'b0;
    lnk2.link_ck = 1'b0;
    lnk2.cmd = dbar_pkg::DBAR_CMD_NOP;
    lnk2.bank = 2'h1;
    lnk2.addr = 12'h010;
    failures = 0;
    num_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_single();
    t_banks();
    t_gapless();
    t_autopre();
    t_idle_read();
    repeat (60) @(posedge clk);
    check("dq_oe", 32'(lnk.dq_oe), 32'h0);
    print_verdict();
  end
endmodule

// [sim/dbar_sva.sv]
`timescale 1ns/1ps
module dbar_sva
(
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                link_ck,
  input wire dbar_pkg::dbar_cmd_t cmd,
  input wire logic [1:0]          bank,
  input wire logic [11:0]         addr,
  input wire logic [31:0]         dq_out,
  input wire logic                dq_oe,
  input wire logic [3:0]          read_strobe,
  input wire logic                strobe_oe,
  input wire logic                term_on
);
  localparam int BCLK = dbar_pkg::LINK_DIV * dbar_pkg::BURST_LEN / 2;
  logic       link_q;
  logic [3:0] gap;
  logic [7:0] run;
  wire        rise = link_ck & ~link_q;
  // link clocks since the last activate, and length of each drive run
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      link_q <= 1'b0;
      gap <= 4'hF;
      run <= 8'h00;
    end
    else
    begin
      link_q <= link_ck;
      run <= dq_oe ? run + 8'h01 : 8'h00;
      if (rise && cmd == dbar_pkg::DBAR_CMD_ACT)
        gap <= 4'h1;
      else if (rise && gap != 4'hF)
        gap <= gap + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  term_off_a: assert property (dq_oe |-> !term_on)
    else $error("termination on while driving data");
  lanes_same_a: assert property (strobe_oe |-> read_strobe == 4'h0 || read_strobe == 4'hF)
    else $error("byte lane strobes differ");
  dq_release_a: assert property (dq_oe |-> strobe_oe)
    else $error("data driven without strobe");
  preamble_a: assert property ($rose(strobe_oe) |-> read_strobe == 4'hF)
    else $error("strobe does not start high");
  burst_len_a: assert property ($fell(dq_oe) |-> run % 8'(BCLK) == 8'h00)
    else $error("burst cut short");
  edge_align_a: assert property (dq_oe && $changed(dq_out) |-> $changed(read_strobe))
    else $error("data change off strobe edge");
  strobe_hold_a: assert property (strobe_oe && $changed(read_strobe) |=> $stable(read_strobe) [*2])
    else $error("strobe half period wrong");
  act_space_a: assert property (rise && cmd == dbar_pkg::DBAR_CMD_ACT |-> gap >= dbar_pkg::RRD_CNT)
    else $error("activates too close");
endmodule
